// ==== hw/dfir_defs.svh ====
`ifndef DFIR_DEFS_SVH
`define DFIR_DEFS_SVH
// ==================================================
// Control word 0 field positions.
`define DFIR_CW0_DF_MSB      3
`define DFIR_CW0_DF_LSB      0
`define DFIR_CW0_DUAL_BIT    4
`define DFIR_CW0_ODDSYM_BIT  5
`define DFIR_CW0_EVENA_BIT   6
`define DFIR_CW0_EVENB_BIT   7
`define DFIR_CW0_SRCB_BIT    8
// ==================================================
// Control word 1 field positions.
`define DFIR_CW1_DATA_A_BIT  0
`define DFIR_CW1_COEF_A_BIT  1
`define DFIR_CW1_DATA_B_BIT  2
`define DFIR_CW1_COEF_B_BIT  3
`define DFIR_CW1_REVOFF_BIT  4
`define DFIR_CW1_RPOS_MSB    8
`define DFIR_CW1_RPOS_LSB    5
`define DFIR_CW1_RNDOFF_BIT  9
// ==================================================
// Coefficient write address fields.
`define DFIR_ADR_COEF_BIT    8
`define DFIR_ADR_SET_MSB     7
`define DFIR_ADR_SET_LSB     3
`define DFIR_ADR_CELL_BIT    2
`define DFIR_ADR_BANK_MSB    1
`define DFIR_ADR_BANK_LSB    0
// ==================================================
// Sizes and arithmetic constants.
`define DFIR_STAGES          4
`define DFIR_DLY_MAX         16
`define DFIR_LIFO_DEPTH      16
`define DFIR_SETS            32
`define DFIR_FIFO_DEPTH      32
`define DFIR_RESULT_W        28
`define DFIR_ROUND_BASE      8
`define DFIR_SCALE_SHIFT     10
`endif

// ==== hw/dfir_pkg.sv ====
package dfir_pkg;
   // ==================================================
   // Shared types.
   typedef logic [9:0]         dfir_sample_t;
   typedef logic signed [11:0] dfir_oper_t;
   typedef logic [27:0]        dfir_result_t;
   typedef enum logic [1:0]
   {
      DFIR_SCALED = 2'b00,
      DFIR_SUM    = 2'b01,
      DFIR_ONLY_A = 2'b10,
      DFIR_ONLY_B = 2'b11
   } dfir_combine_e;
endpackage

// ==== hw/dfir_stream_if.sv ====
`timescale 1ns/1ps
// ==================================================
// Valid/ready word stream between datapath and buffer.
interface dfir_stream_if #(parameter int W = 28) ();
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ==== hw/dfir_fifo.sv ====
`timescale 1ns/1ps
// ==================================================
// Result buffer with honest full and empty.
module dfir_fifo #(
   parameter int WIDTH = 28,
   parameter int DEPTH = 32
) (
   // Clock and reset.
   input  logic             clk,
   input  logic             rst,
   // Filling side.
   dfir_stream_if.snk       push,
   // Draining side.
   output logic             popValid,
   input  logic             popReady,
   output logic [WIDTH-1:0] popData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrQ;
   logic [AW-1:0]    rdQ;
   logic [AW:0]      cntQ;
   logic             wrEn;
   logic             rdEn;

   // Ready drops when full, which stalls the whole datapath upstream.
   assign push.ready = (cntQ != (AW+1)'(DEPTH));
   assign popValid   = (cntQ != '0);
   assign wrEn       = push.valid & push.ready;
   assign rdEn       = popValid & popReady;
   assign popData    = mem[rdQ];

   // Storage carries no reset; only valid words are ever presented.
   always_ff @(posedge clk)
   begin
      if (wrEn)
         mem[wrQ] <= push.data;
   end

   // Pointers and fill count.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wrQ  <= '0;
         rdQ  <= '0;
         cntQ <= '0;
      end
      else
      begin
         if (wrEn)
            wrQ <= wrQ + 1'b1;
         if (rdEn)
            rdQ <= rdQ + 1'b1;
         if (wrEn && !rdEn)
            cntQ <= cntQ + 1'b1;
         else if (rdEn && !wrEn)
            cntQ <= cntQ - 1'b1;
      end
   end
endmodule

// ==== hw/dfir_feedback.sv ====
`timescale 1ns/1ps
`include "dfir_defs.svh"
// ==================================================
// Forward-to-reverse transfer: ping-pong LIFOs or a delay stage.
module dfir_feedback (
   // Clock and reset.
   input  logic       clk,
   input  logic       rst,
   // Control.
   input  logic       shift_enable_alt_n,
   input  logic       swapEvt,
   input  logic       reverseOn,
   input  logic [3:0] df,
   // Data.
   input  logic [9:0] din,
   output logic [9:0] dout
);
   localparam logic [4:0] FULL = 5'(`DFIR_LIFO_DEPTH);
   logic [9:0] lifo [2][`DFIR_LIFO_DEPTH];
   logic [9:0] dlyQ [`DFIR_DLY_MAX];
   logic [4:0] cntQ [2];
   logic       wSelQ;
   logic [9:0] popQ;
   logic [4:0] wCnt;
   logic [4:0] rCnt;

   // Next fill levels of the written and the read LIFO.
   assign wCnt = (cntQ[wSelQ] != FULL) ? cntQ[wSelQ] + 5'h01 : cntQ[wSelQ];
   assign rCnt = (cntQ[~wSelQ] != 5'h00) ? cntQ[~wSelQ] - 5'h01 : 5'h00;

   // Write side of the ping-pong pair; overflow beyond depth is dropped.
   always_ff @(posedge clk)
   begin
      if (shift_enable_alt_n && cntQ[wSelQ] != FULL)
         lifo[wSelQ][cntQ[wSelQ][3:0]] <= din;
   end

   // Pop from the read LIFO, swap roles on a transfer strobe.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cntQ[0] <= '0;
         cntQ[1] <= '0;
         wSelQ   <= 1'b0;
         popQ    <= '0;
      end
      else if (shift_enable_alt_n)
      begin
         popQ <= (cntQ[~wSelQ] != 5'h00) ? lifo[~wSelQ][4'(cntQ[~wSelQ] - 5'h01)] : '0;
         if (swapEvt)
         begin
            // The block just closed is read back last-in first-out.
            cntQ[wSelQ]  <= wCnt;
            cntQ[~wSelQ] <= 5'h00;
            wSelQ        <= ~wSelQ;
         end
         else
         begin
            cntQ[wSelQ]  <= wCnt;
            cntQ[~wSelQ] <= rCnt;
         end
      end
   end

   // Non-reversing delay stage of decimation length.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < `DFIR_DLY_MAX; i++)
            dlyQ[i] <= '0;
      end
      else if (shift_enable_alt_n)
      begin
         dlyQ[0] <= din;
         for (int i = 1; i < `DFIR_DLY_MAX; i++)
            dlyQ[i] <= dlyQ[i-1];
      end
   end

   // Output selector feeding the reverse line.
   assign dout = reverseOn ? popQ : dlyQ[df];
endmodule

// ==== hw/dfir_top.sv ====
`timescale 1ns/1ps
`include "dfir_defs.svh"
// ==================================================
// Operation
// - Decimation factor sets only inter-tap delay length.
// - Single mode chains both cells' delay lines.
// - Reversal on: ping-pong LIFOs feed reverse line.
// - Strobe and shift low swap LIFO roles.
// - Reversed block length equals strobe period.
// - Reversal off: delay stage feeds reverse line.
// - Shift enable high freezes both delay lines.
// - Dual mode: B input from A or B.
// - Single mode: A stage four feeds B.
// - Odd taps tap before last stage-three register.
// - ALU adds or subtracts per symmetry bit.
// - Deasserted gate zeroes its ALU operand.
// - Thirty-two sets, four coefficients per cell.
// - Coefficient address: set, cell, bank fields.
// - Accumulate low: clear feedback, load holding.
// - Accumulate high: sum runs, holding unchanged.
// - Output select: scaled sum, sum, A, B.
// - Unsigned output only for all-unsigned even.
// - Rounding adds one at selected weight.
// - Round position bits 8-5, enable bit 9 low.
// - Word 1 bit 4 low enables reversal.
// - Word 0 bit 4 low selects single filter.
module dfir_top (
   // Clock and reset.
   input  logic        clk,
   input  logic        rst,
   // Sample inputs.
   input  logic [9:0]  sample_in_a,
   input  logic [9:0]  sample_in_b,
   // Per-clock control strobes.
   input  logic        block_transfer_strobe_n,
   input  logic        shift_enable_n,
   input  logic        forward_operand_gate_n,
   input  logic        reverse_operand_gate_n,
   input  logic        accumulate_control,
   input  logic [4:0]  coefficient_set_select,
   input  logic [1:0]  output_combine_select,
   // Configuration words.
   input  logic [9:0]  control_word0,
   input  logic [9:0]  reversal_control_word,
   // Coefficient write port.
   input  logic        config_write_strobe,
   input  logic [8:0]  config_write_addr,
   input  logic [9:0]  config_write_data,
   // Result stream.
   output logic [27:0] filter_result,
   output logic        result_valid,
   input  logic        result_ready,
   output logic        datapath_ready
);
   // ==================================================
   // Configuration decode.
   logic [3:0] df;
   logic       singleMode;
   logic       oddSym;
   logic       srcB;
   logic       reverseOn;
   logic       roundOn;
   logic [3:0] roundPos;
   logic       signedOut;
   logic [1:0] evenTaps;
   logic [1:0] dataSigned;
   logic [1:0] coefSigned;

   assign df         = control_word0[`DFIR_CW0_DF_MSB:`DFIR_CW0_DF_LSB];
   assign singleMode = ~control_word0[`DFIR_CW0_DUAL_BIT];
   assign oddSym     = control_word0[`DFIR_CW0_ODDSYM_BIT];
   assign srcB       = control_word0[`DFIR_CW0_SRCB_BIT];
   assign evenTaps   = {control_word0[`DFIR_CW0_EVENB_BIT], control_word0[`DFIR_CW0_EVENA_BIT]};
   assign dataSigned = {reversal_control_word[`DFIR_CW1_DATA_B_BIT], reversal_control_word[`DFIR_CW1_DATA_A_BIT]};
   assign coefSigned = {reversal_control_word[`DFIR_CW1_COEF_B_BIT], reversal_control_word[`DFIR_CW1_COEF_A_BIT]};
   assign reverseOn  = ~reversal_control_word[`DFIR_CW1_REVOFF_BIT];
   assign roundOn    = ~reversal_control_word[`DFIR_CW1_RNDOFF_BIT];
   assign roundPos   = reversal_control_word[`DFIR_CW1_RPOS_MSB:`DFIR_CW1_RPOS_LSB];
   // Any signed operand or odd symmetry makes the result two's complement.
   assign signedOut  = oddSym | (|dataSigned) | (|coefSigned);

   // Operand extension, shared by data and coefficient paths.
   function automatic dfir_pkg::dfir_oper_t dfirExt(input logic [9:0] v, input logic sgn);
      dfirExt = sgn ? {{2{v[9]}}, v} : {2'b00, v};
   endfunction

   // ==================================================
   // Stall and shift control.
   dfir_stream_if #(.W(`DFIR_RESULT_W)) pushIf ();
   logic adv;
   logic shift_enable_alt_n;
   logic swapEvt;

   // A full result buffer freezes every pipeline stage together.
   assign adv            = pushIf.ready;
   assign datapath_ready = adv;
   assign shift_enable_alt_n        = adv & ~shift_enable_n;
   assign swapEvt        = shift_enable_alt_n & ~block_transfer_strobe_n;

   // ==================================================
   // Input latch: a frozen line keeps the last latched sample.
   dfir_pkg::dfir_sample_t sampleAQ;
   dfir_pkg::dfir_sample_t sampleBQ;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sampleAQ <= '0;
         sampleBQ <= '0;
      end
      else if (shift_enable_alt_n)
      begin
         sampleAQ <= sample_in_a;
         sampleBQ <= sample_in_b;
      end
   end

   // ==================================================
   // Forward and reverse decimation lines.
   logic [9:0] fwdQ   [2][`DFIR_STAGES][`DFIR_DLY_MAX];
   logic [9:0] revQ   [2][`DFIR_STAGES][`DFIR_DLY_MAX];
   logic [9:0] fwdOut [2][`DFIR_STAGES];
   logic [9:0] revOut [2][`DFIR_STAGES];
   logic [9:0] cellIn [2];
   logic [9:0] revIn  [2];
   logic [9:0] tap    [2];
   logic [9:0] fbOut  [2];

   // Cell routing between the single and dual topologies.
   assign cellIn[0] = sampleAQ;
   assign cellIn[1] = singleMode ? fwdOut[0][`DFIR_STAGES-1] : (srcB ? sampleBQ : sampleAQ);
   assign revIn[1]  = fbOut[1];
   assign revIn[0]  = singleMode ? revOut[1][0] : fbOut[0];

   genvar c;
   genvar s;
   generate
      for (c = 0; c < 2; c++)
      begin : g_cell
         for (s = 0; s < `DFIR_STAGES; s++)
         begin : g_stage
            logic [9:0] fIn;
            logic [9:0] rIn;
            if (s == 0)
            begin : g_first
               assign fIn = cellIn[c];
            end
            else
            begin : g_next
               assign fIn = fwdOut[c][s-1];
            end
            if (s == `DFIR_STAGES-1)
            begin : g_rlast
               assign rIn = revIn[c];
            end
            else
            begin : g_rnext
               assign rIn = revOut[c][s+1];
            end

            // Shift both lines only while shifting is enabled.
            always_ff @(posedge clk or posedge rst)
            begin
               if (rst)
               begin
                  for (int i = 0; i < `DFIR_DLY_MAX; i++)
                  begin
                     fwdQ[c][s][i] <= '0;
                     revQ[c][s][i] <= '0;
                  end
               end
               else if (shift_enable_alt_n)
               begin
                  fwdQ[c][s][0] <= fIn;
                  revQ[c][s][0] <= rIn;
                  for (int i = 1; i < `DFIR_DLY_MAX; i++)
                  begin
                     fwdQ[c][s][i] <= fwdQ[c][s][i-1];
                     revQ[c][s][i] <= revQ[c][s][i-1];
                  end
               end
            end

            // Tap length is factor plus one; control paths ignore it.
            assign fwdOut[c][s] = fwdQ[c][s][df];
            assign revOut[c][s] = revQ[c][s][df];
         end

         // Odd lengths take the sample entering the last stage-three register.
         assign tap[c] = evenTaps[c] ? fwdOut[c][2] :
                         (df == 4'h0) ? fwdOut[c][1] : fwdQ[c][2][4'(df - 4'h1)];

         dfir_feedback u_feedback (
            .clk       (clk),
            .rst       (rst),
            .shift_enable_alt_n   (shift_enable_alt_n),
            .swapEvt   (swapEvt),
            .reverseOn (reverseOn),
            .df        (df),
            .din       (tap[c]),
            .dout      (fbOut[c])
         );
      end
   endgenerate

   // ==================================================
   // Coefficient bank, written through the configuration port.
   logic [9:0] coefMem [2][4][`DFIR_SETS];
   logic [4:0] cselQ;

   always_ff @(posedge clk)
   begin
      if (config_write_strobe && config_write_addr[`DFIR_ADR_COEF_BIT])
         coefMem[config_write_addr[`DFIR_ADR_CELL_BIT]]
                [config_write_addr[`DFIR_ADR_BANK_MSB:`DFIR_ADR_BANK_LSB]]
                [config_write_addr[`DFIR_ADR_SET_MSB:`DFIR_ADR_SET_LSB]] <= config_write_data;
   end

   // Registering the set select keeps products already in flight intact.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cselQ <= '0;
      else if (adv)
         cselQ <= coefficient_set_select;
   end

   // ==================================================
   // ALUs and multipliers.
   dfir_pkg::dfir_oper_t aluQ  [2][4];
   logic signed [23:0]   prodQ [2][4];

   generate
      for (c = 0; c < 2; c++)
      begin : g_mac
         for (s = 0; s < 4; s++)
         begin : g_tap
            dfir_pkg::dfir_oper_t opA;
            dfir_pkg::dfir_oper_t opB;
            // A gated operand reads as zero, leaving a, -a or b.
            assign opA = forward_operand_gate_n ? '0 : dfirExt(fwdOut[c][s], dataSigned[c]);
            assign opB = reverse_operand_gate_n ? '0 : dfirExt(revOut[c][s], dataSigned[c]);

            // Pre-add stage, then product with the registered set.
            always_ff @(posedge clk or posedge rst)
            begin
               if (rst)
               begin
                  aluQ[c][s]  <= '0;
                  prodQ[c][s] <= '0;
               end
               else if (adv)
               begin
                  aluQ[c][s]  <= oddSym ? opB - opA : opB + opA;
                  prodQ[c][s] <= 24'(aluQ[c][s]) * 24'(dfirExt(coefMem[c][s][cselQ], coefSigned[c]));
               end
            end
         end
      end
   endgenerate

   // ==================================================
   // Accumulators and output holding registers.
   logic signed [27:0] sumC  [2];
   logic signed [27:0] accQ  [2];
   logic signed [27:0] holdQ [2];
   logic               holdValidQ;

   generate
      for (c = 0; c < 2; c++)
      begin : g_acc
         assign sumC[c] = 28'(prodQ[c][0]) + 28'(prodQ[c][1]) + 28'(prodQ[c][2]) + 28'(prodQ[c][3]);

         // Low accumulate control restarts the sum and publishes the old one.
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               accQ[c]  <= '0;
               holdQ[c] <= '0;
            end
            else if (adv)
            begin
               accQ[c] <= (accumulate_control ? accQ[c] : 28'sh0000000) + sumC[c];
               if (!accumulate_control)
                  holdQ[c] <= accQ[c];
            end
         end
      end
   endgenerate

   // ==================================================
   // Output mux/adder with rounding.
   dfir_pkg::dfir_result_t combined;
   dfir_pkg::dfir_result_t scaledB;
   dfir_pkg::dfir_result_t roundAdd;
   dfir_pkg::dfir_result_t resultQ;
   logic                   outValidQ;

   // Unsigned results must not smear the top bit when scaled down.
   assign scaledB  = signedOut ? 28'(holdQ[1] >>> `DFIR_SCALE_SHIFT) :
                                 28'(holdQ[1] >> `DFIR_SCALE_SHIFT);
   // The shift amount is five bits wide, so codes above seven do not wrap back to low weights.
   assign roundAdd = roundOn ? 28'(28'h0000001 << ({1'b0, roundPos} + 5'(`DFIR_ROUND_BASE))) : 28'h0000000;

   always_comb
   begin
      unique case (dfir_pkg::dfir_combine_e'(output_combine_select))
         dfir_pkg::DFIR_SCALED : combined = holdQ[0] + scaledB;
         dfir_pkg::DFIR_SUM    : combined = holdQ[0] + holdQ[1];
         dfir_pkg::DFIR_ONLY_A : combined = holdQ[0];
         dfir_pkg::DFIR_ONLY_B : combined = holdQ[1];
      endcase
   end

   // Each holding-register load yields one result word.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         holdValidQ <= 1'b0;
         outValidQ  <= 1'b0;
         resultQ    <= '0;
      end
      else if (adv)
      begin
         holdValidQ <= ~accumulate_control;
         outValidQ  <= holdValidQ;
         if (holdValidQ)
            resultQ <= combined + roundAdd;
      end
   end

   assign pushIf.valid = outValidQ & adv;
   assign pushIf.data  = resultQ;

   // ==================================================
   // Result buffer.
   dfir_fifo #(
      .WIDTH (`DFIR_RESULT_W),
      .DEPTH (`DFIR_FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rst      (rst),
      .push     (pushIf),
      .popValid (result_valid),
      .popReady (result_ready),
      .popData  (filter_result)
   );
endmodule

// ==== tb/dfir_top_chk.sv ====
`timescale 1ns/1ps
// ==================================================
// Port-level checks on the result stream and the zeroed datapath.
module dfir_top_chk (
   // Clock and reset.
   input wire logic        clk,
   input wire logic        rst,
   // Watched controls.
   input wire logic        accumulate_control,
   input wire logic        forward_operand_gate_n,
   input wire logic        reverse_operand_gate_n,
   input wire logic [9:0]  reversal_control_word,
   // Watched result stream.
   input wire logic [27:0] filter_result,
   input wire logic        result_valid,
   input wire logic        result_ready,
   input wire logic        datapath_ready
);
   logic [3:0]  quietCnt_q;
   logic [27:0] expRound;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Counts clocks with both operands gated off; it saturates so a long run never wraps to a false start.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         quietCnt_q <= 4'h0;
      else if (!(forward_operand_gate_n && reverse_operand_gate_n && datapath_ready)
               || !$stable(reversal_control_word))
         quietCnt_q <= 4'h0;
      else if (quietCnt_q != 4'hf)
         quietCnt_q <= quietCnt_q + 4'h1;
   end
   // Word expected when every product is zero: only the round bit remains.
   assign expRound = reversal_control_word[9] ? 28'h0 : 28'h1 << ({1'b0, reversal_control_word[8:5]} + 5'h08);
   full_has_data_a: assert property (!datapath_ready |-> result_valid)
      else $error("Datapath stalled with an empty buffer.");
   head_holds_a: assert property (result_valid && !result_ready |=> result_valid && $stable(filter_result))
      else $error("Head word changed before it was taken.");
   word_after_hold_a: assert property ($rose(result_valid) |-> $past(!accumulate_control, 3))
      else $error("Result word without a holding load.");
   no_hold_quiet_a: assert property ((!result_valid && accumulate_control) [*3] |=> !result_valid)
      else $error("Result word while accumulating.");
   fill_needs_push_a: assert property ($fell(datapath_ready) |-> $past(result_valid && !result_ready))
      else $error("Buffer became full without a push.");
   drain_needs_pop_a: assert property ($fell(result_valid) |-> $past(result_ready))
      else $error("Buffer emptied without a pop.");
   space_needs_pop_a: assert property ($rose(datapath_ready) |-> $past(result_ready))
      else $error("Buffer space appeared without a pop.");
   zero_operands_a: assert property ($rose(result_valid) && quietCnt_q >= 4'h8 && reversal_control_word[9]
      |-> filter_result == 28'h0)
      else $error("Gated operands gave a nonzero word.");
   round_weight_a: assert property ($rose(result_valid) && quietCnt_q >= 4'h8
      && !reversal_control_word[9] |-> filter_result == expRound)
      else $error("Round bit at the wrong weight.");
endmodule

bind dfir_top dfir_top_chk dfir_top_chk_inst (
   .clk                    (clk),
   .rst                    (rst),
   .accumulate_control     (accumulate_control),
   .forward_operand_gate_n (forward_operand_gate_n),
   .reverse_operand_gate_n (reverse_operand_gate_n),
   .reversal_control_word  (reversal_control_word),
   .filter_result          (filter_result),
   .result_valid           (result_valid),
   .result_ready           (result_ready),
   .datapath_ready         (datapath_ready)
);

// ==== tb/dfir_source.sv ====
`timescale 1ns/1ps
// ==================================================
// Sample source and block strobe controller.
module dfir_source (
   // Clock and reset.
   input wire logic  clk,
   input wire logic  rst,
   // Strobe period in clocks.
   input wire logic [3:0] period,
   // Toward the block.
   output logic       strobeN,
   output logic [9:0] sampleA,
   output logic [9:0] sampleB
);
   logic [3:0] phase_q;
   logic [8:0] ramp_q;
   // Free-running phase, wrapping to zero at the period; both counters step on the falling edge.
   // Period one keeps the strobe asserted every clock.
   always_ff @(negedge clk or posedge rst)
   begin
      if (rst)
      begin
         phase_q <= 4'h0;
         ramp_q  <= 9'h000;
      end
      else
      begin
         phase_q <= (phase_q + 4'h1 == period) ? 4'h0 : phase_q + 4'h1;
         ramp_q  <= ramp_q + 9'h001;
      end
   end
   // An odd ramp never reaches zero, so products stay nonzero.
   assign strobeN = (phase_q != 4'h0);
   assign sampleA = {ramp_q, 1'b1};
   assign sampleB = ~sampleA;
endmodule

// ==== tb/dfir_top_bench.sv ====
`timescale 1ns/1ps
// ==================================================
// Self-checking bench for the filter datapath.
module dfir_top_bench;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        shiftN = 1'b0;
   logic        fwdN = 1'b0;
   logic        revN = 1'b1;
   logic        acc = 1'b0;
   logic [4:0]  csel = 5'h00;
   logic [1:0]  mux = 2'h2;
   logic [9:0]  cw0 = 10'h0d0;
   logic [9:0]  rcw = 10'h210;
   logic        wrStb = 1'b0;
   logic [8:0]  wrAddr = 9'h000;
   logic [9:0]  wrData = 10'h000;
   logic        rdy = 1'b1;
   logic        strobeN;
   logic [9:0]  sampleA;
   logic [9:0]  sampleB;
   logic [27:0] res;
   logic        vld;
   logic        dpRdy;
   int          miscompares = 0;
   int          samplesChecked = 0;
   // Clock of 40 ns.
   always #20 clk = ~clk;
   // Far side: samples and block strobe.
   dfir_source dfir_source_inst (.clk(clk), .rst(rst), .period(4'h1), .strobeN(strobeN),
      .sampleA(sampleA), .sampleB(sampleB));
   // Block under test.
   dfir_top dfir_top_inst (.clk(clk), .rst(rst), .sample_in_a(sampleA), .sample_in_b(sampleB),
      .block_transfer_strobe_n(strobeN), .shift_enable_n(shiftN), .forward_operand_gate_n(fwdN),
      .reverse_operand_gate_n(revN), .accumulate_control(acc), .coefficient_set_select(csel),
      .output_combine_select(mux), .control_word0(cw0), .reversal_control_word(rcw),
      .config_write_strobe(wrStb), .config_write_addr(wrAddr), .config_write_data(wrData),
      .filter_result(res), .result_valid(vld), .result_ready(rdy), .datapath_ready(dpRdy));
   // Compares one value and counts it.
   task automatic check(input logic [27:0] seen, input logic [27:0] exp);
      samplesChecked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("FAIL at %0t ns: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // Prints the verdict and ends the run.
   task automatic finalReport;
      if (miscompares == 0 && samplesChecked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Strobe stays high across back-to-back writes; the caller lowers it.
   task automatic writeCoef(input logic [8:0] a, input logic [9:0] d);
      wrAddr = a;
      wrData = d;
      wrStb  = 1'b1;
      @(negedge clk);
   endtask
   // Waits for the pipeline, then judges whether the word is nonzero.
   task automatic probe(input logic [4:0] s, input logic [1:0] m, input logic e);
      csel = s;
      mux  = m;
      idle(12);
      check({27'h0, res != 28'h0}, {27'h0, e});
   endtask
   // One nonzero coefficient in set 1, cell B, bank 2; an unflagged write must not land.
   task automatic coefSelect;
      for (int i = 0; i < 24; i++)
         writeCoef(9'h100 | 9'(i), 10'h000);
      writeCoef(9'h10e, 10'h055);
      writeCoef(9'h012, 10'h3ff);
      wrStb = 1'b0;
      probe(5'h01, 2'h3, 1'b1);
      probe(5'h01, 2'h2, 1'b0);
      probe(5'h01, 2'h1, 1'b1);
      // Odd symmetry subtracts the forward operand, so the result turns negative.
      cw0 = 10'h0f0;
      probe(5'h01, 2'h3, 1'b1);
      check({27'h0, res[27]}, 28'h1);
      cw0 = 10'h0d0;
      probe(5'h00, 2'h3, 1'b0);
      probe(5'h02, 2'h2, 1'b0);
   endtask
   // Both operands gated off: only the round bit may appear, for round codes 0 to 11 and every output select.
   task automatic zeroRound;
      logic [27:0] exp;
      fwdN = 1'b1;
      csel = 5'h00;
      for (int code = 0; code < 13; code++)
      begin
         rcw = (code == 12) ? 10'h210 : {1'b0, code[3:0], 5'h10};
         mux = code[1:0];
         acc = 1'b1;
         idle(6);
         acc = 1'b0;
         idle(10);
         exp = (code == 12) ? 28'h0 : 28'h1 << (code + 8);
         check(res, exp);
      end
      fwdN = 1'b0;
   endtask
   // Consumer stalls: buffer fills to its depth, then drains completely.
   task automatic fillFifo;
      int n;
      n   = 0;
      acc = 1'b1;
      idle(6);
      rdy = 1'b0;
      acc = 1'b0;
      repeat (45)
      begin
         @(negedge clk);
         if (dpRdy === 1'b1)
            n++;
      end
      check(28'(n), 28'h21);
      check({27'h0, vld}, 28'h1);
      rdy = 1'b1;
      acc = 1'b1;
      idle(45);
      check({27'h0, vld}, 28'h0);
      check({27'h0, dpRdy}, 28'h1);
   endtask
   // Main sequence after three clocks of reset.
   initial
   begin
      idle(3);
      rst = 1'b0;
      coefSelect();
      zeroRound();
      fillFifo();
      finalReport();
   end
   // Cuts a hang short well past the expected run length.
   initial
   begin
      #(40 * 4000);
      miscompares++;
      finalReport();
   end
endmodule
